//--- logic/rsp_defs.vh
// rsp_defs.vh: constants for the return stack and program counter unit.
// assumes it is included by bare name from every design file that needs it.
`ifndef RSP_DEFS_VH
`define RSP_DEFS_VH

// ------------------------------------------------------------
// sizes
// ------------------------------------------------------------
`define RSP_PC_W 21
`define RSP_PTR_W 5
`define RSP_PTR_TOP 5'h1F
`define RSP_PTR_LAST_FREE 5'h1E
`define RSP_PC_STEP 21'h000002

// ------------------------------------------------------------
// register byte offsets on the apb bus
// ------------------------------------------------------------
`define RSP_OFF_STACK_STATUS 8'h00
`define RSP_OFF_TOP_UPPER 8'h04
`define RSP_OFF_TOP_HIGH 8'h08
`define RSP_OFF_TOP_LOW 8'h0C
`define RSP_OFF_PC_LOW 8'h10
`define RSP_OFF_PC_HIGH_LATCH 8'h14
`define RSP_OFF_PC_UPPER_LATCH 8'h18
`define RSP_OFF_CONFIG 8'h1C

// ------------------------------------------------------------
// field positions and reset values
// ------------------------------------------------------------
`define RSP_BIT_FULL 7
`define RSP_BIT_UNDERFLOW 6
`define RSP_BIT_ERR_RESET_EN 0
`define RSP_RST_STACK_STATUS 8'h00
`define RSP_RST_CONFIG 1'b1
`define RSP_RST_PC 21'h000000
`define RSP_RST_LATCH 8'h00

// ------------------------------------------------------------
// sequencer commands
// ------------------------------------------------------------
`define RSP_CMD_STEP 4'h0
`define RSP_CMD_JUMP 4'h1
`define RSP_CMD_CALL 4'h2
`define RSP_CMD_INT_ACK 4'h3
`define RSP_CMD_RETURN 4'h4
`define RSP_CMD_RETURN_LIT 4'h5
`define RSP_CMD_INT_RETURN 4'h6
`define RSP_CMD_PUSH 4'h7
`define RSP_CMD_POP 4'h8

`endif

//--- logic/rsp_stack_ram.v
// rsp_stack_ram.v: 31 x 21 return stack storage, entry 0 has no storage.
// assumes one writer; read data is registered and write-first on collision.
`timescale 1ns/1ns
`include "rsp_defs.vh"

module rsp_stack_ram (
  input wire pclk,
  input wire we,
  input wire [`RSP_PTR_W-1:0] waddr,
  input wire [`RSP_PC_W-1:0] wdata,
  input wire [`RSP_PTR_W-1:0] raddr,
  output reg [`RSP_PC_W-1:0] rdata
);

  reg [`RSP_PC_W-1:0] mem [1:31];

  // ------------------------------------------------------------
  // write port and registered read
  // ------------------------------------------------------------
  always @(posedge pclk) begin
    if (we && (waddr != 5'h00)) begin
      mem[waddr] <= wdata;
    end
  end

  // address zero reads as zero; a same-cycle write is forwarded so the
  // top entry seen by the core is never one cycle stale
  always @(posedge pclk) begin
    if (raddr == 5'h00) begin
      rdata <= 21'h000000;
    end else if (we && (waddr == raddr)) begin
      rdata <= wdata;
    end else begin
      rdata <= mem[raddr];
    end
  end

endmodule // rsp_stack_ram

//--- logic/rsp_core.v
// rsp_core.v: return address stack, fast register shadow and program counter.
// assumes one sequencer command per cycle at most, apb master per amba apb.
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ns
`include "rsp_defs.vh"

module rsp_core (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire core_valid,
  input wire [3:0] core_cmd,
  input wire core_fast,
  input wire [20:0] core_target,
  input wire [7:0] status_in,
  input wire [7:0] working_reg_in,
  input wire [7:0] bank_select_reg_in,
  output reg [20:0] pc,
  output reg stack_reset,
  output reg shadow_restore,
  output reg [7:0] status_out,
  output reg [7:0] working_reg_out,
  output reg [7:0] bank_select_reg_out
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  reg [4:0] pointer_bits;
  reg stack_full_flag;
  reg stack_underflow_flag;
  reg stack_error_reset_enable;
  reg [7:0] pc_high_latch;
  reg [4:0] pc_upper_latch;
  reg [7:0] shadow_status;
  reg [7:0] shadow_working;
  reg [7:0] shadow_bank;

  reg [4:0] next_ptr;
  reg [20:0] next_pc;
  reg next_full;
  reg next_unf;
  reg [7:0] next_lat_hi;
  reg [4:0] next_lat_up;
  reg next_reset;
  reg next_restore;
  reg save_shadow;
  reg ram_we;
  reg [4:0] ram_waddr;
  reg [20:0] ram_wdata;
  reg do_push;
  reg do_pop;
  reg pop_loads_pc;
  reg [31:0] next_rdata;
  reg next_err;

  wire [20:0] top_entry;
  wire setup_phase;
  wire access_done;
  wire wr_en;
  wire rd_en;
  wire [20:0] pc_plus_step;
  wire [20:0] target_even;

  assign setup_phase = psel & ~penable;
  assign access_done = psel & penable & pready;
  assign wr_en = access_done & pwrite & ~pslverr;
  assign rd_en = access_done & ~pwrite & ~pslverr;
  assign pc_plus_step = pc + `RSP_PC_STEP;
  assign target_even = {core_target[20:1], 1'b0};

  // ------------------------------------------------------------
  // stack storage, read address follows the next pointer
  // ------------------------------------------------------------
  // 31 by 21 storage
  rsp_stack_ram rsp_stack_ram_inst (
    .pclk(pclk),
    .we(ram_we),
    .waddr(ram_waddr),
    .wdata(ram_wdata),
    .raddr(next_ptr),
    .rdata(top_entry)
  );

  // ------------------------------------------------------------
  // next-state logic; core actions after software writes so they win
  // ------------------------------------------------------------
  always @* begin
    next_ptr = pointer_bits;
    next_pc = pc;
    next_full = stack_full_flag;
    next_unf = stack_underflow_flag;
    next_lat_hi = pc_high_latch;
    next_lat_up = pc_upper_latch;
    next_reset = 1'b0;
    next_restore = 1'b0;
    save_shadow = 1'b0;
    ram_we = 1'b0;
    ram_waddr = pointer_bits;
    ram_wdata = top_entry;
    do_push = 1'b0;
    do_pop = 1'b0;
    pop_loads_pc = 1'b0;
    if (wr_en) begin
      case (paddr)
        `RSP_OFF_STACK_STATUS: begin
          // flags clear on a written zero, pointer free
          next_ptr = pwdata[4:0];
          if (!pwdata[`RSP_BIT_FULL]) begin
            next_full = 1'b0;
          end
          if (!pwdata[`RSP_BIT_UNDERFLOW]) begin
            next_unf = 1'b0;
          end
        end
        `RSP_OFF_TOP_UPPER: begin
          ram_we = (pointer_bits != 5'h00);
          ram_wdata = {pwdata[4:0], top_entry[15:0]};
        end
        `RSP_OFF_TOP_HIGH: begin
          ram_we = (pointer_bits != 5'h00);
          ram_wdata = {top_entry[20:16], pwdata[7:0], top_entry[7:0]};
        end
        `RSP_OFF_TOP_LOW: begin
          ram_we = (pointer_bits != 5'h00);
          ram_wdata = {top_entry[20:8], pwdata[7:0]};
        end
        `RSP_OFF_PC_LOW: begin
          // latches move into the upper pc bytes
          next_pc = {pc_upper_latch, pc_high_latch, pwdata[7:1], 1'b0};
        end
        `RSP_OFF_PC_HIGH_LATCH: begin
          next_lat_hi = pwdata[7:0];
        end
        `RSP_OFF_PC_UPPER_LATCH: begin
          next_lat_up = pwdata[4:0];
        end
        default: begin
          next_ptr = pointer_bits;
        end
      endcase
    end
    // low byte read captures upper pc
    if (rd_en && (paddr == `RSP_OFF_PC_LOW)) begin
      next_lat_hi = pc[15:8];
      next_lat_up = pc[20:16];
    end
    if (core_valid) begin
      case (core_cmd)
        `RSP_CMD_STEP: begin
          next_pc = pc_plus_step;
        end
        `RSP_CMD_JUMP: begin
          next_pc = target_even;
        end
        `RSP_CMD_CALL: begin
          do_push = 1'b1;
          next_pc = target_even;
          save_shadow = core_fast;
        end
        `RSP_CMD_INT_ACK: begin
          do_push = 1'b1;
          next_pc = target_even;
          save_shadow = 1'b1;
        end
        `RSP_CMD_RETURN, `RSP_CMD_RETURN_LIT: begin
          do_pop = 1'b1;
          pop_loads_pc = 1'b1;
          next_restore = core_fast & (core_cmd == `RSP_CMD_RETURN);
        end
        `RSP_CMD_INT_RETURN: begin
          do_pop = 1'b1;
          pop_loads_pc = 1'b1;
          next_restore = core_fast;
        end
        `RSP_CMD_PUSH: begin
          do_push = 1'b1;
          next_pc = pc_plus_step;
        end
        `RSP_CMD_POP: begin
          do_pop = 1'b1;
          next_pc = pc_plus_step;
        end
        // unused codes leave any software pc write in place
        default: begin
          do_push = 1'b0;
        end
      endcase
    end
    if (do_push) begin
      ram_wdata = pc;
      ram_waddr = pointer_bits + 5'h01;
      if (pointer_bits == `RSP_PTR_TOP) begin
        next_full = 1'b1;
        next_ptr = `RSP_PTR_TOP;
        if (stack_error_reset_enable) begin
          next_reset = 1'b1;
          next_ptr = 5'h00;
          next_pc = `RSP_RST_PC;
        end
      end else if (pointer_bits == `RSP_PTR_LAST_FREE) begin
        next_full = 1'b1;
        ram_we = 1'b1;
        if (stack_error_reset_enable) begin
          // store pc+2, reset, pointer to zero
          ram_wdata = pc_plus_step;
          next_reset = 1'b1;
          next_ptr = 5'h00;
          next_pc = `RSP_RST_PC;
        end else begin
          next_ptr = `RSP_PTR_TOP;
        end
      end else begin
        ram_we = 1'b1;
        next_ptr = pointer_bits + 5'h01;
      end
    end
    if (do_pop) begin
      if (pointer_bits == 5'h00) begin
        // empty pop: zero to pc on a return or with error reset, flag, pointer stays
        next_unf = 1'b1;
        if (pop_loads_pc) begin
          next_pc = `RSP_RST_PC;
        end
        next_reset = stack_error_reset_enable;
        if (stack_error_reset_enable) begin
          next_pc = `RSP_RST_PC;
        end
      end else begin
        if (pop_loads_pc) begin
          next_pc = {top_entry[20:1], 1'b0};
        end
        next_ptr = pointer_bits - 5'h01;
      end
    end
  end

  // ------------------------------------------------------------
  // apb read data, decoded in the setup cycle
  // ------------------------------------------------------------
  always @* begin
    next_rdata = 32'h00000000;
    next_err = 1'b0;
    if (paddr[1:0] != 2'b00) begin
      next_err = 1'b1;
    end else begin
      case (paddr)
        `RSP_OFF_STACK_STATUS: next_rdata = {24'h000000, stack_full_flag, stack_underflow_flag, 1'b0, pointer_bits};
        `RSP_OFF_TOP_UPPER: next_rdata = {27'h0000000, top_entry[20:16]};
        `RSP_OFF_TOP_HIGH: next_rdata = {24'h000000, top_entry[15:8]};
        `RSP_OFF_TOP_LOW: next_rdata = {24'h000000, top_entry[7:0]};
        // only the low byte is direct
        `RSP_OFF_PC_LOW: next_rdata = {24'h000000, pc[7:0]};
        `RSP_OFF_PC_HIGH_LATCH: next_rdata = {24'h000000, pc_high_latch};
        `RSP_OFF_PC_UPPER_LATCH: next_rdata = {27'h0000000, pc_upper_latch};
        `RSP_OFF_CONFIG: next_rdata = {31'h00000000, stack_error_reset_enable};
        default: next_err = 1'b1;
      endcase
    end
  end

  // ------------------------------------------------------------
  // apb slave: one wait-free access phase, data registered in setup
  // ------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (setup_phase) begin
      pready <= 1'b1;
      pslverr <= next_err;
      prdata <= pwrite ? 32'h00000000 : next_rdata;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pointer_bits <= 5'h00;
      stack_full_flag <= 1'b0;
      stack_underflow_flag <= 1'b0;
      stack_error_reset_enable <= `RSP_RST_CONFIG;
      pc <= `RSP_RST_PC;
      pc_high_latch <= `RSP_RST_LATCH;
      pc_upper_latch <= 5'h00;
      stack_reset <= 1'b0;
    end else begin
      pointer_bits <= next_ptr;
      stack_full_flag <= next_full;
      stack_underflow_flag <= next_unf;
      pc <= next_pc;
      pc_high_latch <= next_lat_hi;
      pc_upper_latch <= next_lat_up;
      stack_reset <= next_reset;
      if (wr_en && (paddr == `RSP_OFF_CONFIG)) begin
        stack_error_reset_enable <= pwdata[`RSP_BIT_ERR_RESET_EN];
      end
    end
  end

  // ------------------------------------------------------------
  // fast register shadow, hidden from software
  // ------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shadow_status <= 8'h00;
      shadow_working <= 8'h00;
      shadow_bank <= 8'h00;
      shadow_restore <= 1'b0;
      status_out <= 8'h00;
      working_reg_out <= 8'h00;
      bank_select_reg_out <= 8'h00;
    end else begin
      if (save_shadow) begin
        shadow_status <= status_in;
        shadow_working <= working_reg_in;
        shadow_bank <= bank_select_reg_in;
      end
      shadow_restore <= next_restore;
      if (next_restore) begin
        status_out <= shadow_status;
        working_reg_out <= shadow_working;
        bank_select_reg_out <= shadow_bank;
      end
    end
  end

endmodule // rsp_core

//--- test/rsp_core_props.sv
// rsp_core_props.sv: port-level checks on rsp_core, bound to every instance.
// assumes one pclk domain with presetn as its asynchronous reset.
`timescale 1ns/1ns
`include "rsp_defs.vh"

module rsp_core_props (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire core_valid,
  input wire [3:0] core_cmd,
  input wire core_fast,
  input wire [20:0] core_target,
  input wire [7:0] status_in,
  input wire [7:0] working_reg_in,
  input wire [7:0] bank_select_reg_in,
  input wire [20:0] pc,
  input wire stack_reset,
  input wire shadow_restore,
  input wire [7:0] status_out,
  input wire [7:0] working_reg_out,
  input wire [7:0] bank_select_reg_out
);
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [23:0] shadow_ref;

  // ----------------------------------------
  // reference shadow, saved on ack or fast call
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shadow_ref <= 24'h000000;
    end else if (core_valid && (core_cmd == `RSP_CMD_INT_ACK || (core_cmd == `RSP_CMD_CALL && core_fast))) begin
      shadow_ref <= {status_in, working_reg_in, bank_select_reg_in};
    end
  end

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_fast_iret;
    core_valid && core_cmd == `RSP_CMD_INT_RETURN && core_fast;
  endsequence
  sequence s_pc_low_wr;
    psel && penable && pready && pwrite && paddr == `RSP_OFF_PC_LOW && !core_valid;
  endsequence

  property p_pc_even;
    pc[0] == 1'b0;
  endproperty
  property p_step;
    core_valid && core_cmd == `RSP_CMD_STEP |=> pc == $past(pc) + `RSP_PC_STEP;
  endproperty
  property p_jump;
    core_valid && core_cmd == `RSP_CMD_JUMP |=> pc == ($past(core_target) & 21'h1FFFFE);
  endproperty
  property p_call;
    core_valid && core_cmd == `RSP_CMD_CALL |=> stack_reset || pc == ($past(core_target) & 21'h1FFFFE);
  endproperty
  property p_fast_ret;
    s_fast_iret |=> shadow_restore;
  endproperty
  property p_plain_ret;
    core_valid && core_cmd == `RSP_CMD_RETURN && !core_fast |=> !shadow_restore;
  endproperty
  property p_shadow;
    shadow_restore |-> {status_out, working_reg_out, bank_select_reg_out} == shadow_ref;
  endproperty
  property p_pc_low;
    s_pc_low_wr |=> pc[7:0] == ($past(pwdata[7:0]) & 8'hFE);
  endproperty
  property p_err_pc;
    stack_reset |-> pc == `RSP_RST_PC ##1 !stack_reset;
  endproperty
  property p_ready;
    s_setup |=> pready ##1 !pready;
  endproperty

  a_pc_even: assert property (p_pc_even) else $error("pc bit 0 set");
  a_step: assert property (p_step) else $error("step did not add two");
  a_jump: assert property (p_jump) else $error("jump target not loaded");
  a_call: assert property (p_call) else $error("call target not loaded");
  a_fast_ret: assert property (p_fast_ret) else $error("fast return without restore");
  a_plain_ret: assert property (p_plain_ret) else $error("plain return restored");
  a_shadow: assert property (p_shadow) else $error("shadow values differ");
  a_pc_low: assert property (p_pc_low) else $error("pc low byte write lost");
  a_err_pc: assert property (p_err_pc) else $error("stack reset pulse wrong");
  a_ready: assert property (p_ready) else $error("pready timing wrong");
endmodule // rsp_core_props

bind rsp_core rsp_core_props rsp_core_props_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pready, .core_valid, .core_cmd, .core_fast, .core_target, .status_in, .working_reg_in, .bank_select_reg_in,
  .pc, .stack_reset, .shadow_restore, .status_out, .working_reg_out, .bank_select_reg_out);

//--- test/rsp_seq_model.sv
// rsp_seq_model.sv: instruction sequencer model issuing commands to rsp_core.
// assumes its tasks are entered just after a rising edge of pclk.
`timescale 1ns/1ns
`include "rsp_defs.vh"

module rsp_seq_model (
  input wire pclk,
  input wire irq_hold,
  output logic hold_expired,
  output logic core_valid,
  output logic [3:0] core_cmd,
  output logic core_fast,
  output logic [20:0] core_target,
  output logic [7:0] status_in,
  output logic [7:0] working_reg_in,
  output logic [7:0] bank_select_reg_in
);
  initial begin
    hold_expired = 1'b0;
    core_valid = 1'b0;
    core_cmd = 4'hF;
    core_fast = 1'b0;
    core_target = 21'h000000;
    {status_in, working_reg_in, bank_select_reg_in} = 24'h000000;
  end

  task automatic set_regs(input logic [23:0] v);
    {status_in, working_reg_in, bank_select_reg_in} <= v;
  endtask

  // idle lets the sequencer answer slowly; fields are scrambled once released
  task automatic issue(input logic [3:0] c, input logic f, input logic [20:0] t, input int idle);
    int n;
    for (n = 0; n < 64 && c == `RSP_CMD_INT_ACK && irq_hold; n++) @(posedge pclk);
    if (n == 64) hold_expired <= 1'b1;
    repeat (idle) @(posedge pclk);
    core_valid <= 1'b1;
    core_cmd <= c;
    core_fast <= f;
    core_target <= t;
    @(posedge pclk);
    core_valid <= 1'b0;
    core_cmd <= ~c;
    core_fast <= ~f;
    core_target <= ~t;
    @(posedge pclk);
  endtask
endmodule // rsp_seq_model

//--- test/return_stack_and_pc_unit_tb.sv
// return_stack_and_pc_unit_tb.sv: self-checking bench for rsp_core over apb.
// assumes the bound checker and rsp_seq_model on the command side.
`timescale 1ns/1ns
`include "rsp_defs.vh"

module return_stack_and_pc_unit_tb;
  typedef struct {logic [3:0] c; logic [20:0] t; logic [20:0] pc; logic [7:0] st; logic [20:0] top;} rsp_row_t;
  logic pclk, presetn, psel, penable, pwrite, irq_hold, pready, pslverr, perr, hold_expired;
  logic core_valid, core_fast, stack_reset, shadow_restore;
  logic [7:0] paddr, status_in, working_reg_in, bank_select_reg_in, status_out, working_reg_out, bank_select_reg_out;
  logic [31:0] pwdata, prdata, q;
  logic [3:0] core_cmd;
  logic [20:0] core_target, pc, tp;
  int bad_count, tests_run, rst_seen, n0, i;
  rsp_row_t rows [8];

  rsp_core rsp_core_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .core_valid, .core_cmd, .core_fast, .core_target, .status_in, .working_reg_in, .bank_select_reg_in, .pc,
    .stack_reset, .shadow_restore, .status_out, .working_reg_out, .bank_select_reg_out);
  rsp_seq_model rsp_seq_model_inst (.pclk, .irq_hold, .hold_expired, .core_valid, .core_cmd, .core_fast, .core_target,
    .status_in, .working_reg_in, .bank_select_reg_in);

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (stack_reset === 1'b1) rst_seen <= rst_seen + 1;
  end

  task automatic close_out(input logic hung);
    if (hung) bad_count++;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // ----------------------------------------
  // apb master: hold request until pready
  // ----------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 16) begin
      $display("wrong value at %0t: no pready", $time);
      close_out(1'b1);
    end
    q = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd_top;
    apb(1'b0, `RSP_OFF_TOP_UPPER, 32'h0);
    tp[20:16] = q[4:0];
    apb(1'b0, `RSP_OFF_TOP_HIGH, 32'h0);
    tp[15:8] = q[7:0];
    apb(1'b0, `RSP_OFF_TOP_LOW, 32'h0);
    tp[7:0] = q[7:0];
  endtask

  initial begin
    {presetn, psel, penable, pwrite, irq_hold, paddr, pwdata} = 45'h0;
    {bad_count, tests_run, rst_seen} = 96'h0;
    rows = '{'{`RSP_CMD_STEP, 21'h0, 21'h2, 8'h00, 21'h0}, '{`RSP_CMD_JUMP, 21'h1235, 21'h1234, 8'h00, 21'h0},
      '{`RSP_CMD_CALL, 21'h100, 21'h100, 8'h01, 21'h1234}, '{`RSP_CMD_INT_ACK, 21'h8, 21'h8, 8'h02, 21'h100},
      '{`RSP_CMD_INT_RETURN, 21'h0, 21'h100, 8'h01, 21'h1234}, '{`RSP_CMD_PUSH, 21'h0, 21'h102, 8'h02, 21'h100},
      '{`RSP_CMD_POP, 21'h0, 21'h104, 8'h01, 21'h1234}, '{`RSP_CMD_RETURN_LIT, 21'h0, 21'h1234, 8'h00, 21'h0}};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `RSP_OFF_STACK_STATUS, 32'h0);
    chk(q, 32'h0);
    apb(1'b0, `RSP_OFF_CONFIG, 32'h0);
    chk(q, 32'h1);
    for (i = 0; i < 8; i++) begin
      rsp_seq_model_inst.issue(rows[i].c, 1'b0, rows[i].t, i % 3);
      chk({11'h0, pc}, {11'h0, rows[i].pc});
      apb(1'b0, `RSP_OFF_STACK_STATUS, 32'h0);
      chk(q, {24'h0, rows[i].st});
      rd_top;
      chk({11'h0, tp}, {11'h0, rows[i].top});
    end
    // empty pop with error reset off
    apb(1'b1, `RSP_OFF_CONFIG, 32'h0);
    n0 = rst_seen;
    rsp_seq_model_inst.issue(`RSP_CMD_RETURN, 1'b0, 21'h0, 0);
    chk({11'h0, pc}, 32'h0);
    apb(1'b0, `RSP_OFF_STACK_STATUS, 32'h0);
    chk(q, 32'h40);
    chk(rst_seen - n0, 32'h0);
    apb(1'b1, `RSP_OFF_STACK_STATUS, 32'h0);
    apb(1'b0, `RSP_OFF_STACK_STATUS, 32'h0);
    chk(q, 32'h0);
    // 32 calls: the last must not overwrite entry 31
    for (i = 0; i < 32; i++) rsp_seq_model_inst.issue(`RSP_CMD_CALL, 1'b0, 21'h200 + 21'(i * 2), 0);
    apb(1'b0, `RSP_OFF_STACK_STATUS, 32'h0);
    chk(q, 32'h9F);
    rd_top;
    chk({11'h0, tp}, 32'h23A);
    apb(1'b1, `RSP_OFF_STACK_STATUS, 32'h3F);
    apb(1'b0, `RSP_OFF_STACK_STATUS, 32'h0);
    chk(q, 32'h1F);
    irq_hold <= 1'b1;
    apb(1'b1, `RSP_OFF_TOP_UPPER, 32'h01);
    apb(1'b1, `RSP_OFF_TOP_HIGH, 32'h20);
    apb(1'b1, `RSP_OFF_TOP_LOW, 32'h10);
    irq_hold <= 1'b0;
    rsp_seq_model_inst.issue(`RSP_CMD_RETURN, 1'b0, 21'h0, 0);
    chk({11'h0, pc}, 32'h12010);
    // 31st push with error reset on, from pointer 30
    apb(1'b1, `RSP_OFF_CONFIG, 32'h1);
    n0 = rst_seen;
    rsp_seq_model_inst.issue(`RSP_CMD_JUMP, 1'b0, 21'h400, 0);
    rsp_seq_model_inst.issue(`RSP_CMD_CALL, 1'b0, 21'h600, 1);
    chk({11'h0, pc}, 32'h0);
    apb(1'b0, `RSP_OFF_STACK_STATUS, 32'h0);
    chk(q, 32'h80);
    chk(rst_seen - n0, 32'h1);
    apb(1'b1, `RSP_OFF_STACK_STATUS, 32'h9F);
    rd_top;
    chk({11'h0, tp}, 32'h402);
    apb(1'b1, `RSP_OFF_STACK_STATUS, 32'h0);
    // upper pc bytes only through the latches
    apb(1'b1, `RSP_OFF_PC_HIGH_LATCH, 32'h56);
    apb(1'b1, `RSP_OFF_PC_UPPER_LATCH, 32'h07);
    apb(1'b1, `RSP_OFF_PC_LOW, 32'h9B);
    chk({11'h0, pc}, 32'h7569A);
    rsp_seq_model_inst.issue(`RSP_CMD_JUMP, 1'b0, 21'hABCDE, 0);
    apb(1'b0, `RSP_OFF_PC_LOW, 32'h0);
    chk(q, 32'hDE);
    apb(1'b0, `RSP_OFF_PC_HIGH_LATCH, 32'h0);
    chk(q, 32'hBC);
    apb(1'b0, `RSP_OFF_PC_UPPER_LATCH, 32'h0);
    chk(q, 32'h0A);
    apb(1'b1, `RSP_OFF_PC_HIGH_LATCH, 32'h11);
    rsp_seq_model_inst.issue(`RSP_CMD_CALL, 1'b0, 21'h300, 0);
    rsp_seq_model_inst.issue(`RSP_CMD_RETURN, 1'b0, 21'h0, 0);
    apb(1'b0, `RSP_OFF_PC_HIGH_LATCH, 32'h0);
    chk(q, 32'h11);
    // shadow saved by ack and fast call, restored by fast returns
    rsp_seq_model_inst.set_regs(24'hA1B2C3);
    rsp_seq_model_inst.issue(`RSP_CMD_INT_ACK, 1'b0, 21'h8, 0);
    rsp_seq_model_inst.set_regs(24'h0);
    rsp_seq_model_inst.issue(`RSP_CMD_INT_RETURN, 1'b1, 21'h0, 0);
    chk({7'h0, shadow_restore, status_out, working_reg_out, bank_select_reg_out}, 32'h1A1B2C3);
    rsp_seq_model_inst.set_regs(24'h445566);
    rsp_seq_model_inst.issue(`RSP_CMD_CALL, 1'b1, 21'h700, 0);
    rsp_seq_model_inst.set_regs(24'h0);
    rsp_seq_model_inst.issue(`RSP_CMD_RETURN, 1'b1, 21'h0, 0);
    chk({7'h0, shadow_restore, status_out, working_reg_out, bank_select_reg_out}, 32'h1445566);
    // empty return with error reset on: zero pc, underflow and a reset pulse
    n0 = rst_seen;
    rsp_seq_model_inst.issue(`RSP_CMD_RETURN_LIT, 1'b0, 21'h0, 0);
    chk({11'h0, pc}, 32'h0);
    apb(1'b0, `RSP_OFF_STACK_STATUS, 32'h0);
    chk(q, 32'h40);
    chk(rst_seen - n0, 32'h1);
    apb(1'b0, 8'h24, 32'h0);
    chk({perr, q[30:0]}, 32'h80000000);
    // unmapped offset 8'h20 answers with pslverr, and no interrupt hold expired
    apb(1'b0, 8'h20, 32'h0);
    chk({perr, q[30:0]}, 32'h80000000);
    chk({31'h0, hold_expired}, 32'h0);
    close_out(1'b0);
  end
endmodule // return_stack_and_pc_unit_tb
